// ==== verilog/rpc_map.svh ====
// Reset pin configuration: bit positions, defaults and counts
`ifndef RPC_MAP_SVH
`define RPC_MAP_SVH

// Data bus width and bus bits that carry configuration
`define RPC_BUS_W         16
`define RPC_BIT_BOOT      0
`define RPC_BIT_ARB       1
`define RPC_BIT_ACLASS    2
`define RPC_BIT_ADDR_LO   3
`define RPC_BIT_BUSCTL    8
`define RPC_BIT_IRQ       9
`define RPC_BIT_TEST      11
`define RPC_ADDR_N        5

// Pad sample vector: bus bits, then clock source, then breakpoint
`define RPC_SMP_W         18
`define RPC_SMP_CLKSRC    16
`define RPC_SMP_BREAKPOINT_IN      17

// Undriven pads read high through the pull-ups
`define RPC_SMP_RESET     18'h3ffff
`define RPC_SYNC_STAGES   3

// Default pin functions: all mode-select levels high
`define RPC_FUNC_RESET    10'h303
`define RPC_MODE_RESET    3'h2

`endif

// ==== verilog/rpc_pkg.sv ====
// Types for the reset pin configuration latch
package rpc_pkg;

   // Pin functions chosen at reset, may be rewritten by software
   typedef struct packed {
      logic       boot_wide;      // 1: boot_select 16-bit port
      logic       chip_selects;   // 1: select lines 0-2, 0: arbitration
      logic       access_class;   // 1: access_class_lines drive
      logic [4:0] addr_lines;     // Bit i: address line 19+i replaces select 6+i
      logic       bus_control;    // 1: strobes, acks, size; 0: gpio_group_e
      logic       irq_pins;       // 1: interrupt inputs; 0: gpio_group_f
   } rpc_func_t;

   // Device modes fixed at reset
   typedef struct packed {
      logic test_slave;           // Factory test slave mode
      logic clk_synth;            // 1: synth_oscillator, 0: crystal_input
      logic debug_en;             // Background debug mode
   } rpc_mode_t;

endpackage

// ==== verilog/rpc_sync3.sv ====
// Three-stage pad synchroniser with agreement filter
module rpc_sync3 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         sys_rst,
   // Pad side
   input  wire logic [W-1:0] pad_in,
   input  wire logic [W-1:0] reset_val,
   // Filtered level
   output logic      [W-1:0] level
);

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] level_ff;

   // Runs through reset so the pads are tracked while reset is held
   always_ff @(posedge ref_clk) begin
      s1_ff <= pad_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
   end

   // A change counts once stages two and three agree
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < W; i++) begin
         if (s2_ff[i] == s3_ff[i]) begin
            level_ff[i] <= s3_ff[i];
         end
      end
   end

   assign level = level_ff;

   // Unused in this stage; only tied off, the filter has no reset and runs through it
   logic unused_rst;
   assign unused_rst = sys_rst & (|reset_val);

endmodule

// ==== verilog/rpc_latch.sv ====
// Reset pin configuration latch: captures bus levels at reset release
//
// Behaviour
// - Capture every configuration pin when reset releases; hold as configuration.
// - An undriven bus pin reads as one through its pull-up.
// - Captured high picks the default function (address straps: only if all higher address straps are high); low picks the alternate.
// - Bit 0 high: boot select 16-bit; low: 8-bit.
// - Bit 8 high: bus control pins; low: general port E.
// - Bit 11 high: test slave off; low: test slave on.
// - Clock source high: synthesizer clocks system; low: crystal input directly.
// - Bit 1 high: select lines 0-2; low: request, grant, acknowledge.
// - Bit 9 low: interrupt pins to port F; high: interrupt inputs.
// - After reset, software pin assignment writes override captured functions.
`include "rpc_map.svh"

module rpc_latch (
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  sys_rst,
   // Data bus pads during reset
   input  wire logic [`RPC_BUS_W-1:0] data_bus_in,
   input  wire logic [`RPC_BUS_W-1:0] data_bus_driven,
   // Mode pads
   input  wire logic                  clock_source_select,
   input  wire logic                  breakpoint_in,
   // Pin assignment write from software
   input  wire logic                  pin_assign_wr,
   input  rpc_pkg::rpc_func_t         pin_assign_data,
   // Configuration out
   output rpc_pkg::rpc_func_t         pin_func,
   output rpc_pkg::rpc_mode_t         dev_mode,
   output rpc_pkg::rpc_func_t         captured_func,
   output logic                       cfg_valid
);

   logic [`RPC_SMP_W-1:0] pad_raw;
   logic [`RPC_SMP_W-1:0] pad_lvl;
   logic                  rst_d_ff;
   logic                  release_evt;
   logic                  cfg_valid_ff;
   rpc_pkg::rpc_func_t    cap_func_ff;
   rpc_pkg::rpc_func_t    func_ff;
   rpc_pkg::rpc_mode_t    mode_ff;
   rpc_pkg::rpc_func_t    nxt_func;
   rpc_pkg::rpc_mode_t    nxt_mode;

   // Pull-ups hold undriven bus pins high
   always_comb begin
      for (int i = 0; i < `RPC_BUS_W; i++) begin
         pad_raw[i] = data_bus_driven[i] ? data_bus_in[i] : 1'b1;
      end
      pad_raw[`RPC_SMP_CLKSRC] = clock_source_select;
      pad_raw[`RPC_SMP_BREAKPOINT_IN]   = breakpoint_in;
   end

   rpc_sync3 #(
      .W (`RPC_SMP_W)
   ) u_sync (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .pad_in    (pad_raw),
      .reset_val (`RPC_SMP_RESET),
      .level     (pad_lvl)
   );

   // Decode of filtered levels; high picks the default function, except an address strap with a low strap above it
   always_comb begin
      nxt_func.boot_wide    = pad_lvl[`RPC_BIT_BOOT];
      nxt_func.chip_selects = pad_lvl[`RPC_BIT_ARB];
      nxt_func.access_class = ~pad_lvl[`RPC_BIT_ACLASS];
      for (int i = 0; i < `RPC_ADDR_N; i++) begin
         nxt_func.addr_lines[i] = 1'b0;
         for (int j = i; j < `RPC_ADDR_N; j++) begin
            if (!pad_lvl[`RPC_BIT_ADDR_LO + j]) begin
               nxt_func.addr_lines[i] = 1'b1;
            end
         end
      end
      nxt_func.bus_control  = pad_lvl[`RPC_BIT_BUSCTL];
      nxt_func.irq_pins     = pad_lvl[`RPC_BIT_IRQ];
      nxt_mode.test_slave   = ~pad_lvl[`RPC_BIT_TEST];
      nxt_mode.clk_synth    = pad_lvl[`RPC_SMP_CLKSRC];
      nxt_mode.debug_en     = ~pad_lvl[`RPC_SMP_BREAKPOINT_IN];
   end

   // Release edge of reset
   always_ff @(posedge ref_clk) begin
      rst_d_ff <= sys_rst;
   end

   assign release_evt = rst_d_ff & ~sys_rst;

   // Captured configuration, fixed from the release onward
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cap_func_ff <= rpc_pkg::rpc_func_t'(`RPC_FUNC_RESET);
         mode_ff     <= rpc_pkg::rpc_mode_t'(`RPC_MODE_RESET);
      end else if (release_evt) begin
         cap_func_ff <= nxt_func;
         mode_ff     <= nxt_mode;
      end
   end

   // Active pin functions: captured at release, then software may rewrite
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         func_ff <= rpc_pkg::rpc_func_t'(`RPC_FUNC_RESET);
      end else if (release_evt) begin
         func_ff <= nxt_func;
      end else if (pin_assign_wr && cfg_valid_ff) begin
         func_ff <= pin_assign_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cfg_valid_ff <= 1'b0;
      end else if (release_evt) begin
         cfg_valid_ff <= 1'b1;
      end
   end

   assign pin_func      = func_ff;
   assign dev_mode      = mode_ff;
   assign captured_func = cap_func_ff;
   assign cfg_valid     = cfg_valid_ff;

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   logic [`RPC_SMP_W-1:0] lvl_at_rel;
   assign lvl_at_rel = pad_lvl;

   capture_boot_a: assert property (release_evt |=>
      cap_func_ff.boot_wide == $past(lvl_at_rel[`RPC_BIT_BOOT]))
      else $error("boot width not captured");

   capture_arb_a: assert property (release_evt |=>
      func_ff.chip_selects == $past(lvl_at_rel[`RPC_BIT_ARB]))
      else $error("arbitration select not captured");

   capture_busctl_a: assert property (release_evt |=>
      cap_func_ff.bus_control == $past(lvl_at_rel[`RPC_BIT_BUSCTL]))
      else $error("bus control select not captured");

   capture_irq_a: assert property (release_evt |=>
      cap_func_ff.irq_pins == $past(lvl_at_rel[`RPC_BIT_IRQ]))
      else $error("interrupt pin select not captured");

   test_slave_a: assert property (release_evt |=>
      mode_ff.test_slave != $past(lvl_at_rel[`RPC_BIT_TEST]))
      else $error("test slave polarity wrong");

   clock_src_a: assert property (release_evt |=>
      mode_ff.clk_synth == $past(lvl_at_rel[`RPC_SMP_CLKSRC]))
      else $error("clock source not captured");

   debug_en_a: assert property (release_evt |=>
      mode_ff.debug_en == !$past(lvl_at_rel[`RPC_SMP_BREAKPOINT_IN]))
      else $error("debug enable polarity wrong");

   access_class_a: assert property (release_evt |=>
      (cap_func_ff.access_class == !$past(lvl_at_rel[`RPC_BIT_ACLASS])) &&
      (cap_func_ff.addr_lines[4] == !$past(lvl_at_rel[`RPC_BIT_ADDR_LO + 4])))
      else $error("function code or address line select wrong");

   hold_cfg_a: assert property (cfg_valid_ff && !release_evt |=>
      $stable(mode_ff) && $stable(cap_func_ff))
      else $error("captured configuration changed after release");

   sw_override_a: assert property (cfg_valid_ff && pin_assign_wr && !release_evt |=>
      func_ff == $past(pin_assign_data))
      else $error("pin assignment write ignored");

   valid_rise_a: assert property (release_evt |=> cfg_valid_ff ##1 cfg_valid_ff)
      else $error("configuration valid not raised");

   valid_hold_a: assert property (cfg_valid_ff |=> cfg_valid_ff)
      else $error("configuration valid dropped outside reset");

   // Defaults while reset is held
   reset_dflt_a: assert property (@(posedge ref_clk) disable iff (1'b0) sys_rst |=>
      (func_ff == rpc_pkg::rpc_func_t'(`RPC_FUNC_RESET)) &&
      (mode_ff == rpc_pkg::rpc_mode_t'(`RPC_MODE_RESET)) && !cfg_valid_ff)
      else $error("reset defaults not applied");

   pull_up_a: assert property ((data_bus_driven == '0) [*4] |=>
      &pad_lvl[`RPC_BUS_W-1:0])
      else $error("undriven bus pins not read high");

   func_rel_a: assert property (release_evt |=>
      func_ff == cap_func_ff)
      else $error("active functions differ from captured ones");

   rel_write_a: assert property (release_evt && pin_assign_wr |=>
      func_ff == cap_func_ff)
      else $error("pin assignment write taken at release");

   // Each low strap turns its select and all below it into address lines
   addr_line0_a: assert property (release_evt |=>
      cap_func_ff.addr_lines[0] == !$past(&lvl_at_rel[`RPC_BIT_ADDR_LO +: `RPC_ADDR_N]))
      else $error("address line 19 select wrong");

   addr_line1_a: assert property (release_evt |=>
      cap_func_ff.addr_lines[1] == !$past(&lvl_at_rel[`RPC_BIT_ADDR_LO + 1 +: 4]))
      else $error("address line 20 select wrong");

   addr_line2_a: assert property (release_evt |=>
      cap_func_ff.addr_lines[2] == !$past(&lvl_at_rel[`RPC_BIT_ADDR_LO + 2 +: 3]))
      else $error("address line 21 select wrong");

   addr_line3_a: assert property (release_evt |=>
      cap_func_ff.addr_lines[3] == !$past(&lvl_at_rel[`RPC_BIT_ADDR_LO + 3 +: 2]))
      else $error("address line 22 select wrong");

   rel_cov_c:   cover property (release_evt ##1 cfg_valid_ff);
   alt_cov_c:   cover property (release_evt ##1 !func_ff.chip_selects && !mode_ff.debug_en);
   write_cov_c: cover property (cfg_valid_ff ##1 pin_assign_wr ##1 func_ff != cap_func_ff);
   test_cov_c:  cover property (release_evt ##1 mode_ff.test_slave);
   addr_cov_c:  cover property (release_evt ##1 cap_func_ff.addr_lines[0]);

endmodule

// ==== bench/rpc_strap_model.sv ====
// Board strap model: drives configuration levels on the data bus around reset
module rpc_strap_model (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // Wanted straps
   input  wire logic [15:0] strap_val,
   input  wire logic [15:0] strap_mask,
   input  wire logic        test_ok,
   // Pads
   output logic      [15:0] data_bus_in,
   output logic      [15:0] data_bus_driven
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0]  hold_ff = 2'h0;
   logic [15:0] noise_ff = 16'h0f0f;
   logic [15:0] val;
   always_comb begin
      val = strap_val;
      if (!test_ok) val[11] = 1'b1;
   end
   // Keep driving a few cycles past release
   always_ff @(posedge ref_clk) begin
      noise_ff <= ~noise_ff;
      if (sys_rst) hold_ff <= 2'h3;
      else if (hold_ff != 2'h0) hold_ff <= hold_ff - 2'h1;
   end
   assign data_bus_driven = (hold_ff != 2'h0) ? strap_mask : 16'h0000;
   assign data_bus_in = (data_bus_driven & val) | (~data_bus_driven & noise_ff);
endmodule

// ==== bench/tb.sv ====
// Testbench for the reset pin configuration latch
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [15:0] strap_val = 16'hffff;
   logic [15:0] strap_mask = 16'h0000;
   logic test_ok = 1'b0;
   logic [15:0] data_bus_in;
   logic [15:0] data_bus_driven;
   logic clock_source_select = 1'b1;
   logic breakpoint_in = 1'b1;
   logic pin_assign_wr = 1'b0;
   rpc_pkg::rpc_func_t pin_assign_data = 10'h000;
   rpc_pkg::rpc_func_t pin_func;
   rpc_pkg::rpc_mode_t dev_mode;
   rpc_pkg::rpc_func_t captured_func;
   logic cfg_valid;
   int bad_count = 0;
   int cmp_count = 0;
   always #12.5 ref_clk = ~ref_clk;
   rpc_strap_model i_strap (.ref_clk(ref_clk), .sys_rst(sys_rst), .strap_val(strap_val),
      .strap_mask(strap_mask), .test_ok(test_ok), .data_bus_in(data_bus_in),
      .data_bus_driven(data_bus_driven));
   rpc_latch i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .data_bus_in(data_bus_in),
      .data_bus_driven(data_bus_driven), .clock_source_select(clock_source_select),
      .breakpoint_in(breakpoint_in), .pin_assign_wr(pin_assign_wr),
      .pin_assign_data(pin_assign_data), .pin_func(pin_func), .dev_mode(dev_mode),
      .captured_func(captured_func), .cfg_valid(cfg_valid));
   function automatic rpc_pkg::rpc_func_t exp_func(input logic [15:0] e);
      rpc_pkg::rpc_func_t r;
      r.boot_wide = e[0];
      r.chip_selects = e[1];
      r.access_class = ~e[2];
      for (int i = 0; i < 5; i++) r.addr_lines[i] = ((~e[7:3]) >> i) != 5'h00;
      r.bus_control = e[8];
      r.irq_pins = e[9];
      return r;
   endfunction
   function automatic rpc_pkg::rpc_mode_t exp_mode(input logic [15:0] e, input logic c, b);
      rpc_pkg::rpc_mode_t r;
      r.test_slave = ~e[11];
      r.clk_synth = c;
      r.debug_en = ~b;
      return r;
   endfunction
   task automatic chk_func(input string n, input rpc_pkg::rpc_func_t e, g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_mode(input string n, input rpc_pkg::rpc_mode_t e, g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic run(input logic [15:0] v, m, input logic c, b, t);
      rpc_pkg::rpc_func_t f;
      rpc_pkg::rpc_func_t d;
      rpc_pkg::rpc_mode_t md;
      logic [15:0] e;
      e = (v & m) | ~m;
      if (!t) e[11] = 1'b1;
      f = exp_func(e);
      md = exp_mode(e, c, b);
      sys_rst = 1'b1;
      strap_val = v;
      strap_mask = m;
      test_ok = t;
      clock_source_select = c;
      breakpoint_in = b;
      pin_assign_wr = 1'b1;
      pin_assign_data = 10'($urandom);
      repeat (8) @(posedge ref_clk);
      #2 chk_bit("cfg_valid", 1'b0, cfg_valid);
      chk_func("pin_func", exp_func(16'hffff), pin_func);
      chk_func("captured_func", exp_func(16'hffff), captured_func);
      chk_mode("dev_mode", exp_mode(16'hffff, 1'b1, 1'b1), dev_mode);
      sys_rst = 1'b0;
      @(posedge ref_clk);
      #2 pin_assign_wr = 1'b0;
      strap_val = ~v;
      clock_source_select = ~c;
      breakpoint_in = ~b;
      chk_bit("cfg_valid", 1'b1, cfg_valid);
      chk_func("pin_func", f, pin_func);
      chk_mode("dev_mode", md, dev_mode);
      repeat (6) @(posedge ref_clk);
      #2 d = 10'($urandom);
      pin_assign_wr = 1'b1;
      pin_assign_data = d;
      chk_func("captured_func", f, captured_func);
      @(posedge ref_clk);
      #2 pin_assign_data = ~d;
      chk_func("pin_func", d, pin_func);
      @(posedge ref_clk);
      #2 pin_assign_wr = 1'b0;
      chk_func("pin_func", ~d, pin_func);
      chk_func("captured_func", f, captured_func);
      chk_mode("dev_mode", md, dev_mode);
   endtask
   task automatic final_report();
      if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      void'($urandom(32'hec910a69));
      repeat (16) @(posedge ref_clk);
      #2 run(16'h0000, 16'hffff, 1'b0, 1'b0, 1'b1);
      run(16'h0000, 16'h0000, 1'b1, 1'b1, 1'b0);
      for (int k = 0; k < 14; k++) begin
         run(16'($urandom), 16'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
      end
      final_report();
   end
   initial begin
      repeat (2000) @(posedge ref_clk);
      bad_count++;
      final_report();
   end
endmodule
